/* bench/ndef_file_address_map_tb.sv */
`timescale 1ns/1ps
`define CHK(a,b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, a, b); end end
module ndef_file_address_map_tb;
  import nfm_pkg::*;
  typedef struct {logic [1:0] f; logic [15:0] a; logic [7:0] n;
    logic [15:0] st; logic [8:0] pa; int ns;} nfm_row_t;
  logic        clk = 0, rst = 1, sv = 0, cv = 0, cw = 0;
  logic [1:0]  sf = 0;
  logic [15:0] ca = 0;
  logic [7:0]  cn = 0, wd = 0, mrd;
  logic        o_cmd_busy, o_mem_en, o_mem_we, o_rd_valid, o_done;
  logic [8:0]  o_mem_addr, fa;
  logic [7:0]  o_mem_wdata, o_rd_data;
  logic [15:0] o_status;
  logic [1:0]  o_sel_state;
  logic [7:0]  rdq [$];
  int          mismatches = 0, check_count = 0, nst;
  nfm_row_t    rows [9] = '{'{2'h3, 16'h0, 8'h10, SW_OK, 9'h180, 16},
    '{2'h3, 16'hf, 8'h02, SW_RANGE, 9'h0, 0},
    '{2'h2, 16'h0, 8'h05, SW_OK, 9'h00c, 5},
    '{2'h2, 16'h2, 8'h01, SW_OK, 9'h010, 1},
    '{2'h2, 16'h171, 8'h01, SW_OK, 9'h17f, 1},
    '{2'h2, 16'h171, 8'h02, SW_RANGE, 9'h0, 0},
    '{2'h2, 16'h0, 8'h00, SW_RANGE, 9'h0, 0},
    '{2'h1, 16'h0, 8'h01, SW_NOSEL, 9'h0, 0},
    '{2'h0, 16'h0, 8'h01, SW_NOSEL, 9'h0, 0}};
  nfm_file_access dut (.i_clk(clk), .i_rst(rst), .i_sel_valid(sv),
    .i_sel_file(sf), .i_cmd_valid(cv), .i_cmd_write(cw), .i_cmd_addr(ca),
    .i_cmd_count(cn), .i_cmd_wdata(wd), .i_mem_rdata(mrd),
    .o_cmd_busy(o_cmd_busy), .o_mem_en(o_mem_en), .o_mem_we(o_mem_we),
    .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
    .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data), .o_done(o_done),
    .o_status(o_status), .o_sel_state(o_sel_state));
  nfm_mem_model mem (.i_clk(clk), .i_en(o_mem_en), .i_we(o_mem_we),
    .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .o_rdata(mrd));
  always #12.5 clk = ~clk;
  always @(negedge clk)
  begin
    if (o_mem_en === 1'b1)
    begin
      if (nst == 0)
        fa = o_mem_addr;
      nst++;
    end
    if (o_rd_valid === 1'b1)
      rdq.push_back(o_rd_data);
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic sel(input logic [1:0] f);
    @(posedge clk);
    #2;
    sv = 1;
    sf = f;
    @(posedge clk);
    #2;
    sv = 0;
    `CHK(o_sel_state, f)
  endtask
  task automatic cmd(input logic wr, input logic [15:0] a,
                     input logic [7:0] n);
    int t;
    nst = 0;
    rdq.delete();
    @(posedge clk);
    #2;
    cv = 1;
    cw = wr;
    ca = a;
    cn = n;
    @(posedge clk);
    #2;
    cv = 0;
    wd = 8'h51;
    for (t = 0; t < 400; t++)
    begin
      @(posedge clk);
      #1;
      if (o_done === 1'b1)
        break;
      #1;
      wd = wd + 8'h01;
    end
    if (t == 400)
      mismatches++;
    `CHK(o_cmd_busy, 1'b0)
  endtask
  initial
  begin
    #(25 * 5000);
    mismatches++;
    tally_and_finish();
  end
  initial
  begin
    repeat (6) @(posedge clk);
    #2;
    rst = 0;
    `CHK(o_status, SW_OK)
    `CHK(o_sel_state, 2'h0)
    $display("test reset done");
    foreach (rows[i])
    begin
      sel(rows[i].f);
      cmd(1'b0, rows[i].a, rows[i].n);
      `CHK(o_status, rows[i].st)
      `CHK(nst, rows[i].ns)
      if (rows[i].ns > 0)
        `CHK(fa, rows[i].pa)
      $display("test %0d done", i);
    end
    sel(2'h3);
    cmd(1'b0, 16'h0, 8'h10);
    `CHK({rdq[2], rdq[3], rdq[4]}, 24'h20003b)
    `CHK({rdq[7], rdq[8], rdq[9], rdq[10]}, 32'h04060103)
    $display("test container done");
    sel(2'h2);
    cmd(1'b0, 16'h0, 8'h05);
    `CHK({rdq[0], rdq[1], rdq[2], rdq[3], rdq[4]}, 40'h0003d00000)
    cmd(1'b1, 16'h1, 8'h02);
    `CHK(fa, 9'h00d)
    `CHK(nst, 2)
    cmd(1'b0, 16'h0, 8'h03);
    `CHK({rdq[0], rdq[1], rdq[2]}, 24'h005152)
    $display("test span done");
    tally_and_finish();
  end
endmodule

/* bench/nfm_mem_model.sv */
`timescale 1ns/1ps
module nfm_mem_model
(
  input  wire logic       i_clk,
  input  wire logic       i_en,
  input  wire logic       i_we,
  input  wire logic [8:0] i_addr,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata
);
  logic [7:0]   mem [0:511];
  logic [119:0] cc;
  initial
  begin
    cc = {56'h000f_20_003b_0034,
          64'h04_06_0103_0032_00_00};
    for (int i = 0; i < 15; i++)
      mem[9'h180 + 9'(i)] = cc[8 * (14 - i) +: 8];
    {mem[9'h00c], mem[9'h00d]} = 16'h0003;
    {mem[9'h010], mem[9'h011], mem[9'h012]} = 24'hd00000;
  end
  always @(posedge i_clk)
  begin
    if (i_en && i_we)
      mem[i_addr] <= i_wdata;
  end
  // Read data stands only while the read strobe stands; junk otherwise
  assign o_rdata = (i_en && !i_we) ? mem[i_addr] : ~mem[i_addr];
endmodule

/* hw/nfm_addr_map.sv */
`timescale 1ns/1ps
module nfm_addr_map
  import nfm_pkg::*;
(
  nfm_map_if.map m
);
  logic [15:0] rel;

  always_comb
  begin
    rel        = 16'h0000;
    m.phys     = 9'h000;
    m.in_range = 1'b0;
    case (m.sel)
      SEL_CC:
      begin
        m.phys     = CC_BASE + m.offset[8:0];
        m.in_range = (m.offset < CC_FILE_SIZE);
      end
      SEL_MSG:
      begin
        if (m.offset < LEN_BYTES)
        begin
          m.phys = LEN_BASE + m.offset[8:0];
        end
        else
        begin
          rel    = m.offset - LEN_BYTES;
          m.phys = MSG_BASE + rel[8:0];
        end
        m.in_range = (m.offset < MSG_FILE_SIZE);
      end
      default:
      begin
        m.phys     = 9'h000;
        m.in_range = 1'b0;
      end
    endcase
  end
endmodule

/* hw/nfm_file_access.sv */
`timescale 1ns/1ps
module nfm_file_access
  import nfm_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_sel_valid,
  input  wire logic [1:0]  i_sel_file,
  input  wire logic        i_cmd_valid,
  input  wire logic        i_cmd_write,
  input  wire logic [15:0] i_cmd_addr,
  input  wire logic [7:0]  i_cmd_count,
  input  wire logic [7:0]  i_cmd_wdata,
  input  wire logic [7:0]  i_mem_rdata,
  output logic             o_cmd_busy,
  output logic             o_mem_en,
  output logic             o_mem_we,
  output logic [8:0]       o_mem_addr,
  output logic [7:0]       o_mem_wdata,
  output logic             o_rd_valid,
  output logic [7:0]       o_rd_data,
  output logic             o_done,
  output logic [15:0]      o_status,
  output logic [1:0]       o_sel_state
);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  nfm_map_if mi ();

  nfm_sel_t    sel_q,    sel_d;
  nfm_state_t  st_q,     st_d;
  logic [15:0] off_q,    off_d;
  logic [7:0]  left_q,   left_d;
  logic        wr_q,     wr_d;
  logic        en_q,     en_d;
  logic        we_q,     we_d;
  logic [8:0]  addr_q,   addr_d;
  logic [7:0]  wdat_q,   wdat_d;
  logic        rv_q,     rv_d;
  logic [7:0]  rdat_q,   rdat_d;
  logic        done_q,   done_d;
  logic [15:0] stat_q,   stat_d;
  logic        rpend_q,  rpend_d;
  logic [16:0] last_off;

  assign mi.sel    = sel_q;
  assign mi.offset = off_q;

  nfm_addr_map u_map
  (
    .m (mi.map)
  );

  // Last byte offset of the request decides range before any memory cycle
  assign last_off = {1'b0, i_cmd_addr} + {9'h000, i_cmd_count} - 17'h00001;

  always_comb
  begin
    sel_d   = sel_q;
    st_d    = st_q;
    off_d   = off_q;
    left_d  = left_q;
    wr_d    = wr_q;
    en_d    = 1'b0;
    we_d    = 1'b0;
    addr_d  = addr_q;
    wdat_d  = wdat_q;
    rv_d    = 1'b0;
    rdat_d  = rdat_q;
    done_d  = 1'b0;
    stat_d  = stat_q;
    rpend_d = 1'b0;
    if (rpend_q)
    begin
      rv_d   = 1'b1;
      rdat_d = i_mem_rdata;
    end
    case (st_q)
      ST_IDLE:
      begin
        if (i_sel_valid)
        begin
          sel_d = nfm_sel_t'(i_sel_file);
        end
        else if (i_cmd_valid)
        begin
          if (sel_q != SEL_CC && sel_q != SEL_MSG)
          begin
            stat_d = SW_NOSEL;
            st_d   = ST_DONE;
          end
          else if (i_cmd_count == 8'h00 || last_off[16] ||
                   (sel_q == SEL_CC && last_off[15:0] >= CC_FILE_SIZE) ||
                   (sel_q == SEL_MSG && last_off[15:0] >= MSG_FILE_SIZE))
          begin
            stat_d = SW_RANGE;
            st_d   = ST_DONE;
          end
          else
          begin
            off_d  = i_cmd_addr;
            left_d = i_cmd_count;
            wr_d   = i_cmd_write;
            stat_d = SW_OK;
            st_d   = ST_RUN;
          end
        end
      end
      ST_RUN:
      begin
        // One byte per cycle; the map hops the gap mid-command
        en_d    = 1'b1;
        we_d    = wr_q;
        addr_d  = mi.phys;
        wdat_d  = i_cmd_wdata;
        rpend_d = ~wr_q;
        off_d   = off_q + 16'h0001;
        left_d  = left_q - 8'h01;
        if (left_q == 8'h01)
        begin
          st_d = ST_DONE;
        end
      end
      ST_DONE:
      begin
        if (!rpend_q)
        begin
          done_d = 1'b1;
          st_d   = ST_IDLE;
        end
      end
      default:
      begin
        st_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      sel_q   <= SEL_NONE;
      st_q    <= ST_IDLE;
      off_q   <= 16'h0000;
      left_q  <= 8'h00;
      wr_q    <= 1'b0;
      en_q    <= 1'b0;
      we_q    <= 1'b0;
      addr_q  <= 9'h000;
      wdat_q  <= 8'h00;
      rv_q    <= 1'b0;
      rdat_q  <= 8'h00;
      done_q  <= 1'b0;
      stat_q  <= SW_OK;
      rpend_q <= 1'b0;
    end
    else
    begin
      sel_q   <= sel_d;
      st_q    <= st_d;
      off_q   <= off_d;
      left_q  <= left_d;
      wr_q    <= wr_d;
      en_q    <= en_d;
      we_q    <= we_d;
      addr_q  <= addr_d;
      wdat_q  <= wdat_d;
      rv_q    <= rv_d;
      rdat_q  <= rdat_d;
      done_q  <= done_d;
      stat_q  <= stat_d;
      rpend_q <= rpend_d;
    end
  end

  logic busy_q;
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      busy_q <= 1'b0;
    end
    else
    begin
      busy_q <= (st_d != ST_IDLE);
    end
  end

  assign o_cmd_busy  = busy_q;
  assign o_mem_en    = en_q;
  assign o_mem_we    = we_q;
  assign o_mem_addr  = addr_q;
  assign o_mem_wdata = wdat_q;
  assign o_rd_valid  = rv_q;
  assign o_rd_data   = rdat_q;
  assign o_done      = done_q;
  assign o_status    = stat_q;
  assign o_sel_state = sel_q;

  chk_cc_base_map: assert property
    ((st_q == ST_RUN && sel_q == SEL_CC) |=>
      (o_mem_en && o_mem_addr == CC_BASE + $past(off_q[8:0])))
    else $error("Container byte mapped to wrong address");

  chk_len_field_map: assert property
    ((st_q == ST_RUN && sel_q == SEL_MSG && off_q < LEN_BYTES) |=>
      (o_mem_addr == LEN_BASE + $past(off_q[8:0])))
    else $error("Length field mapped to wrong address");

  chk_msg_gap_skip: assert property
    ((st_q == ST_RUN && sel_q == SEL_MSG && off_q >= LEN_BYTES) |=>
      (o_mem_addr >= MSG_BASE && o_mem_addr != 9'h00e &&
       o_mem_addr != 9'h00f))
    else $error("Message byte landed in the skipped gap");

  chk_span_gap: assert property
    ((st_q == ST_RUN && sel_q == SEL_MSG && off_q == 16'h0001 &&
      left_q > 8'h01) |=> ##1 (o_mem_en && o_mem_addr == MSG_BASE))
    else $error("Spanning access did not cross the gap");

  chk_no_sel_err: assert property
    ((st_q == ST_IDLE && !i_sel_valid && i_cmd_valid &&
      sel_q != SEL_CC && sel_q != SEL_MSG) |=>
      (!o_mem_en && stat_q == SW_NOSEL) ##1
      (o_done && o_status == SW_NOSEL))
    else $error("Unselected access not refused");

  chk_range_err: assert property
    ((stat_q == SW_RANGE && st_q == ST_DONE) |-> (!o_mem_en && !en_d))
    else $error("Out of range access touched memory");

  chk_sel_update: assert property
    ((!$past(i_sel_valid) || $past(st_q) != ST_IDLE) |-> $stable(sel_q))
    else $error("File selection changed without select");

  chk_byte_count: assert property
    ((st_q == ST_RUN && left_q == 8'h02) |=>
      (st_q == ST_RUN) ##1 (st_q == ST_DONE))
    else $error("Command ran wrong number of bytes");
endmodule

/* hw/nfm_map_if.sv */
`timescale 1ns/1ps
interface nfm_map_if;
  import nfm_pkg::*;
  nfm_sel_t    sel;
  logic [15:0] offset;
  logic [8:0]  phys;
  logic        in_range;
  modport core (output sel, output offset, input phys, input in_range);
  modport map  (input sel, input offset, output phys, output in_range);
endinterface

/* hw/nfm_pkg.sv */
package nfm_pkg;
  localparam logic [8:0]  CC_BASE      = 9'h180;
  localparam logic [8:0]  CC_LAST      = 9'h18f;
  localparam logic [8:0]  LEN_BASE     = 9'h00c;
  localparam logic [8:0]  MSG_BASE     = 9'h010;
  localparam logic [8:0]  MSG_LAST     = 9'h17f;
  localparam logic [15:0] LEN_BYTES    = 16'h0002;
  localparam logic [15:0] CC_FILE_SIZE = 16'h0010;
  localparam logic [15:0] MSG_FILE_SIZE = 16'h0172;
  localparam logic [15:0] SW_OK        = 16'h9000;
  localparam logic [15:0] SW_RANGE     = 16'h6a82;
  localparam logic [15:0] SW_NOSEL     = 16'h6986;

  typedef enum logic [1:0]
  {
    SEL_NONE = 2'h0,
    SEL_APP  = 2'h1,
    SEL_CC   = 2'h3,
    SEL_MSG  = 2'h2
  } nfm_sel_t;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'h0,
    ST_RUN  = 2'h1,
    ST_DONE = 2'h3
  } nfm_state_t;
endpackage
